// ===== flash_block_write_protect.sv
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
// Summary of operation
// - opcodes C0h and 17h work without a prior write enable.
// - program or erase aimed into the protected region is refused.
// - chip erase is refused unless all four protect bits are zero.
// - with write disable bit zero, status writes pass regardless of pin.
// - disable bit one, pin low and quad enable zero freezes protect bits; status write ignored.
// - disable bit one and pin high still lets status writes through.
// - quad enable zero gives the two pins their control functions.
// - quad enable one turns the two pins into data lines three and four.
// - small layout has 1024 blocks numbered 0 to 1023.
// - small layout codes 1 to 10 protect 1 to 512 blocks, doubling.
// - codes 11 to 14 protect 768, 896, 960, 992; code 15 all.
// - select zero protects from the top down, one from block zero up.
// - big layout codes 1 to 8 double from 1; 9 and above protect all.
// - protect, quad and disable bits change only by status write after enable.
// - top/bottom select, once set to bottom, never returns to top.
module flash_block_write_protect (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // register bus, write side
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // register bus, read side
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // decoded commands from the serial front end
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [7:0] cmd_opcode,
    input wire logic [wp_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    // array sequencer
    output logic op_go,
    output logic op_refused,
    output logic [7:0] op_code,
    output logic [wp_pkg::ADDR_W-1:0] op_addr,
    input wire logic op_done,
    // pins
    input wire logic wp_pin,
    output logic pin_ctrl_en,
    output logic quad_lines_en
);
    import wp_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    logic [3:0] bp_q;
    logic quad_enable_q, status_write_disable_q, wel_q, busy_q;
    logic top_bottom_select_q, big_q, go_q, refused_q;
    logic [7:0] rparam_q, bank_q, code_q;
    logic [15:0] refused_cnt_q;
    logic [ADDR_W-1:0] addr_q;

    // ****************************************************************
    // command classification and range check
    // ****************************************************************
    logic cmd_take, is_prog, is_sect, is_half, is_blk, is_chip, is_erase;
    logic [ADDR_W-1:0] span, first_addr, last_addr;
    logic [9:0] first_blk, last_blk, prot_lo, prot_hi;
    logic prot_none, overlap, wp_level, status_lock;
    logic [5:0] status_wr_bits;
    logic [7:0] status_byte;

    assign cmd_ready = ~busy_q;
    assign cmd_take = cmd_valid & cmd_ready;
    assign status_wr_bits = cmd_data[7:2];

    always_comb begin
        is_prog = 1'b0;
        is_sect = 1'b0;
        is_half = 1'b0;
        is_blk = 1'b0;
        is_chip = 1'b0;
        case (cmd_opcode)
            OP_PROG_A, OP_PROG_B, OP_PROG_C, OP_PROG_D, OP_PROG_E, OP_PROG_F: is_prog = 1'b1;
            OP_SECT_A, OP_SECT_B, OP_SECT_C: is_sect = 1'b1;
            OP_HALF_A, OP_HALF_B: is_half = 1'b1;
            OP_BLK_A, OP_BLK_B: is_blk = 1'b1;
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: is_chip = 1'b1;
            default: is_prog = 1'b0;
        endcase
    end

    assign is_erase = is_sect | is_half | is_blk;
    // the whole erased region is checked, not just the address given
    always_comb begin
        span = '0;
        if (is_sect) begin
            span = SPAN_SECTOR;
        end else if (is_half) begin
            span = SPAN_HALF;
        end else if (is_blk) begin
            span = big_q ? SPAN_BLK_BIG : SPAN_BLK_SMALL;
        end
    end

    assign first_addr = cmd_addr & ~span;
    assign last_addr = cmd_addr | span;
    assign first_blk = big_q ? {2'b00, first_addr[25:18]} : first_addr[25:16];
    assign last_blk = big_q ? {2'b00, last_addr[25:18]} : last_addr[25:16];

    wp_range_decode #(
        .BLK_W(10),
        .CNT_W(11)
    ) u_range (
        .bp(bp_q),
        .bottom_sel(top_bottom_select_q),
        .big(big_q),
        .none(prot_none),
        .lo(prot_lo),
        .hi(prot_hi)
    );

    assign overlap = ~prot_none & (last_blk >= prot_lo) & (first_blk <= prot_hi);
    // with quad enabled the pin carries data, so it cannot hold the lock
    assign wp_level = wp_pin | quad_enable_q;
    assign status_lock = status_write_disable_q & ~wp_level;
    assign pin_ctrl_en = ~quad_enable_q;
    assign quad_lines_en = quad_enable_q;

    // ****************************************************************
    // status bits and write enable latch
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bp_q <= BP_RST;
            quad_enable_q <= 1'b0;
            status_write_disable_q <= 1'b0;
            wel_q <= 1'b0;
        end else begin
            if (op_done) begin
                wel_q <= 1'b0;
            end
            if (cmd_take) begin
                if (cmd_opcode == OP_WRITE_ENABLE) begin
                    wel_q <= 1'b1;
                end else if (cmd_opcode == OP_WRITE_DISABLE) begin
                    wel_q <= 1'b0;
                end else if (cmd_opcode == OP_STATUS_WRITE && wel_q && !status_lock) begin
                    bp_q <= cmd_data[ST_WR_LOCK-2:ST_BP_LSB];
                    quad_enable_q <= cmd_data[ST_QUAD_EN];
                    status_write_disable_q <= cmd_data[ST_WR_LOCK];
                    wel_q <= 1'b0;
                end else if (is_erase && wel_q && overlap) begin
                    wel_q <= 1'b0;
                end else if ((cmd_opcode == OP_FUNC_WRITE || cmd_opcode == OP_RPARAM_LOCKED
                             || cmd_opcode == OP_BANK_LOCKED) && wel_q) begin
                    wel_q <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // function and volatile registers
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            top_bottom_select_q <= 1'b0;
            rparam_q <= BYTE_RST;
            bank_q <= BYTE_RST;
        end else if (cmd_take) begin
            if (cmd_opcode == OP_FUNC_WRITE && wel_q && cmd_data[FN_BOTTOM]) begin
                top_bottom_select_q <= 1'b1;
            end
            if (cmd_opcode == OP_RPARAM_FREE
                || (cmd_opcode == OP_RPARAM_LOCKED && wel_q)) begin
                rparam_q <= cmd_data;
            end
            if (cmd_opcode == OP_BANK_FREE || (cmd_opcode == OP_BANK_LOCKED && wel_q)) begin
                bank_q <= cmd_data;
            end
        end
    end

    // ****************************************************************
    // program and erase gate
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            go_q <= 1'b0;
            refused_q <= 1'b0;
            code_q <= BYTE_RST;
            addr_q <= '0;
            busy_q <= 1'b0;
        end else begin
            go_q <= 1'b0;
            refused_q <= 1'b0;
            if (op_done) begin
                busy_q <= 1'b0;
            end
            if (cmd_take && wel_q && (is_prog || is_erase || is_chip)) begin
                code_q <= cmd_opcode;
                addr_q <= cmd_addr;
                if (is_chip ? (bp_q != 4'h0) : overlap) begin
                    refused_q <= 1'b1;
                end else begin
                    go_q <= 1'b1;
                    busy_q <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            refused_cnt_q <= '0;
        end else if (refused_q) begin
            refused_cnt_q <= refused_cnt_q + 16'h0001;
        end
    end
    assign op_go = go_q;
    assign op_refused = refused_q;
    assign op_code = code_q;
    assign op_addr = addr_q;

    // ****************************************************************
    // register bus slave
    // ****************************************************************
    logic aw_held_q, w_held_q, bvalid_q, rvalid_q, rd_hit;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q, rdata_q, rd_mux;
    logic [3:0] w_strb_q;
    logic [1:0] bresp_q, rresp_q;

    assign s_axi_awready = ~aw_held_q & ~bvalid_q;
    assign s_axi_wready = ~w_held_q & ~bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign status_byte = {status_write_disable_q, quad_enable_q, bp_q, wel_q, busy_q};
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            big_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (aw_held_q && w_held_q && !bvalid_q) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= RESP_OKAY;
                case (aw_addr_q)
                    REG_CTRL: begin
                        if (w_strb_q[0]) begin
                            big_q <= w_data_q[0];
                        end
                    end
                    REG_STATUS, REG_FUNC, REG_RANGE, REG_RPARAM, REG_BANK, REG_REFUSED: begin
                        bresp_q <= RESP_OKAY;
                    end
                    default: bresp_q <= RESP_SLVERR;
                endcase
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_mux = '0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            REG_STATUS: rd_mux = {24'h00_0000, status_byte};
            REG_FUNC: rd_mux = {30'h0000_0000, top_bottom_select_q, 1'b0};
            REG_CTRL: rd_mux = {31'h0000_0000, big_q};
            REG_RANGE: rd_mux = {11'h000, prot_none, prot_hi, prot_lo};
            REG_RPARAM: rd_mux = {24'h00_0000, rparam_q};
            REG_BANK: rd_mux = {24'h00_0000, bank_q};
            REG_REFUSED: rd_mux = {16'h0000, refused_cnt_q};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    a_chip_erase_gate: assert property (
        cmd_take && is_chip && wel_q && bp_q != 4'h0 |=> op_refused && !op_go)
        else $error("chip erase ran with protection set");
    a_protected_refuse: assert property (
        cmd_take && (is_prog || is_erase) && wel_q && overlap |=> op_refused && !op_go)
        else $error("program or erase into protected region");
    a_erase_wel_clear: assert property (
        cmd_take && is_erase && wel_q && overlap |=> !wel_q && busy_q == $past(busy_q))
        else $error("refused erase left write enable set");
    a_free_opcodes: assert property (
        cmd_take && !wel_q && cmd_opcode == OP_RPARAM_FREE |=> rparam_q == $past(cmd_data))
        else $error("free read parameter set not taken");
    a_status_lock: assert property (
        cmd_take && cmd_opcode == OP_STATUS_WRITE && status_lock
        |=> $stable(bp_q) && $stable(quad_enable_q) && $stable(status_write_disable_q))
        else $error("locked status bits changed");
    a_status_open: assert property (
        cmd_take && cmd_opcode == OP_STATUS_WRITE && wel_q && !status_write_disable_q
        |=> {status_write_disable_q, quad_enable_q, bp_q} == $past(status_wr_bits) && !wel_q)
        else $error("open status write not applied");
    a_status_needs_wel: assert property (
        !(cmd_take && cmd_opcode == OP_STATUS_WRITE && wel_q) |=> $stable(bp_q))
        else $error("protect bits changed without status write");
    a_tbs_sticky: assert property (
        top_bottom_select_q |=> top_bottom_select_q [*3])
        else $error("bottom select returned to top");
    a_full_small: assert property (
        !big_q && bp_q == 4'hF |-> !prot_none && prot_lo == 10'h000 && prot_hi == 10'h3FF)
        else $error("code 15 does not cover the array");
    a_quad_pins: assert property (
        cmd_take && cmd_opcode == OP_STATUS_WRITE && wel_q && !status_lock
        |=> quad_lines_en == $past(cmd_data[ST_QUAD_EN]) && pin_ctrl_en == !quad_lines_en)
        else $error("pins not handed to quad data");
endmodule

// ===== wp_pkg.sv
package wp_pkg;

    // ****************************************************************
    // command opcodes seen on the command port
    // ****************************************************************
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_FUNC_WRITE = 8'h42;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
    localparam logic [7:0] OP_RPARAM_FREE = 8'hC0;
    localparam logic [7:0] OP_RPARAM_LOCKED = 8'h63;
    localparam logic [7:0] OP_BANK_FREE = 8'h17;
    localparam logic [7:0] OP_BANK_LOCKED = 8'hC5;
    localparam logic [7:0] OP_PROG_A = 8'h02;
    localparam logic [7:0] OP_PROG_B = 8'h12;
    localparam logic [7:0] OP_PROG_C = 8'h32;
    localparam logic [7:0] OP_PROG_D = 8'h38;
    localparam logic [7:0] OP_PROG_E = 8'h34;
    localparam logic [7:0] OP_PROG_F = 8'h3E;
    localparam logic [7:0] OP_SECT_A = 8'hD7;
    localparam logic [7:0] OP_SECT_B = 8'h20;
    localparam logic [7:0] OP_SECT_C = 8'h21;
    localparam logic [7:0] OP_HALF_A = 8'h52;
    localparam logic [7:0] OP_HALF_B = 8'h5C;
    localparam logic [7:0] OP_BLK_A = 8'hD8;
    localparam logic [7:0] OP_BLK_B = 8'hDC;

    // ****************************************************************
    // status and function register layout, reset values
    // ****************************************************************
    localparam int ST_WIP = 0;
    localparam int ST_WEL = 1;
    localparam int ST_BP_LSB = 2;
    localparam int ST_QUAD_EN = 6;
    localparam int ST_WR_LOCK = 7;
    localparam int FN_BOTTOM = 1;
    localparam logic [3:0] BP_RST = 4'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // ****************************************************************
    // array geometry
    // ****************************************************************
    localparam int ADDR_W = 26;
    localparam logic [10:0] BLOCKS_SMALL = 11'h400;
    localparam logic [10:0] BLOCKS_BIG = 11'h100;
    localparam logic [10:0] PROT_CODE11 = 11'h300;
    localparam logic [10:0] PROT_CODE12 = 11'h380;
    localparam logic [10:0] PROT_CODE13 = 11'h3C0;
    localparam logic [10:0] PROT_CODE14 = 11'h3E0;
    localparam logic [3:0] BP_BIG_LAST_STEP = 4'h8;
    localparam logic [25:0] SPAN_SECTOR = 26'h000_0FFF;
    localparam logic [25:0] SPAN_HALF = 26'h000_7FFF;
    localparam logic [25:0] SPAN_BLK_SMALL = 26'h000_FFFF;
    localparam logic [25:0] SPAN_BLK_BIG = 26'h003_FFFF;

    // ****************************************************************
    // register bus map
    // ****************************************************************
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_FUNC = 8'h04;
    localparam logic [7:0] REG_CTRL = 8'h08;
    localparam logic [7:0] REG_RANGE = 8'h0C;
    localparam logic [7:0] REG_RPARAM = 8'h10;
    localparam logic [7:0] REG_BANK = 8'h14;
    localparam logic [7:0] REG_REFUSED = 8'h18;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ===== wp_range_decode.sv
`timescale 1ns/1ps
module wp_range_decode #(
    parameter int BLK_W = 10,
    parameter int CNT_W = 11
) (
    // protection code and layout
    input wire logic [3:0] bp,
    input wire logic bottom_sel,
    input wire logic big,
    // protected block range
    output logic none,
    output logic [BLK_W-1:0] lo,
    output logic [BLK_W-1:0] hi
);
    import wp_pkg::*;

    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] total;

    always_comb begin
        cnt = '0;
        total = big ? BLOCKS_BIG : BLOCKS_SMALL;
        if (big) begin
            if (bp == 4'h0) begin
                cnt = '0;
            end else if (bp <= BP_BIG_LAST_STEP) begin
                cnt = CNT_W'(1) << (bp - 4'h1);
            end else begin
                cnt = BLOCKS_BIG;
            end
        end else begin
            case (bp)
                4'h0: cnt = '0;
                4'hB: cnt = PROT_CODE11;
                4'hC: cnt = PROT_CODE12;
                4'hD: cnt = PROT_CODE13;
                4'hE: cnt = PROT_CODE14;
                4'hF: cnt = BLOCKS_SMALL;
                default: cnt = CNT_W'(1) << (bp - 4'h1);
            endcase
        end
    end

    // top grows down from the last block, bottom grows up from block zero
    assign none = (cnt == '0);
    assign lo = bottom_sel ? '0 : BLK_W'(total - cnt);
    assign hi = bottom_sel ? BLK_W'(cnt - CNT_W'(1)) : BLK_W'(total - CNT_W'(1));
endmodule

// ===== flash_array_model.sv
`timescale 1ns/1ps
// ****************************************************************
// array sequencer stand-in: answers each approved op, alternating fast and slow
// ****************************************************************
module flash_array_model (
    // clock
    input wire logic clk_sys,
    // sequencer handshake
    input wire logic op_go,
    output logic op_done
);
    int wait_n = 0;
    int slow = 0;
    initial op_done = 1'b0;
    always @(posedge clk_sys) begin
        op_done <= 1'b0;
        if (op_go) begin
            wait_n = 1 + 4 * slow;
            slow = 1 - slow;
        end else if (wait_n > 0) begin
            wait_n = wait_n - 1;
            if (wait_n == 0) op_done <= 1'b1;
        end
    end
endmodule

// ===== test_flash_block_write_protect.sv
`timescale 1ns/1ps
module test_flash_block_write_protect;
    import wp_pkg::*;
    // ****************************************************************
    // stimulus and observed signals
    // ****************************************************************
    logic clk_sys = 0, arst_n = 0, wp_pin = 1, cmd_valid = 0;
    logic [7:0] awaddr = 0, araddr = 0, cmd_opcode = 0, cmd_data = 0, op_code;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [3:0] wstrb = 0;
    logic [25:0] cmd_addr = 0, op_addr;
    logic awready, wready, bvalid, arready, rvalid, op_go, op_refused, op_done;
    logic cmd_ready, pin_ctrl_en, quad_lines_en, go_s, ref_s;
    logic [1:0] bresp, rresp, rr;
    int err_count = 0, n_tests = 0;
    always #4 clk_sys = ~clk_sys;
    flash_block_write_protect DUT (.clk_sys(clk_sys), .arst_n(arst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .op_go(op_go), .op_refused(op_refused),
        .op_code(op_code), .op_addr(op_addr), .op_done(op_done), .wp_pin(wp_pin),
        .pin_ctrl_en(pin_ctrl_en), .quad_lines_en(quad_lines_en));
    flash_array_model seq (.clk_sys(clk_sys), .op_go(op_go), .op_done(op_done));
    // ****************************************************************
    // access tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1; wvalid <= 1; bready <= 1;
        // only the watchdog ends a wait, so a hang shows as a failure
        forever begin
            @(posedge clk_sys);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid) begin
                rr = bresp;
                bready <= 0;
                break;
            end
        end
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge clk_sys);
        araddr <= a; arvalid <= 1; rready <= 1;
        forever begin
            @(posedge clk_sys);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid) begin
                rd = rdata;
                rr = rresp;
                rready <= 0;
                break;
            end
        end
    endtask
    // a busy device holds cmd_ready low until the sequencer reports done
    task automatic cmd(input logic [7:0] op, input logic [25:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        cmd_valid <= 1; cmd_opcode <= op; cmd_addr <= a; cmd_data <= d;
        do @(posedge clk_sys);
        while (cmd_ready !== 1'b1);
        cmd_valid <= 0;
        #1 go_s = op_go;
        ref_s = op_refused;
    endtask
    task automatic status_write_cmd(input logic [7:0] d);
        cmd(OP_WRITE_ENABLE, 26'h0, 8'h0);
        cmd(OP_STATUS_WRITE, 26'h0, d);
    endtask
    function automatic logic [31:0] exp_rng(input int c, input bit big, input bit bot);
        int n;
        int tot;
        tot = big ? 256 : 1024;
        if (c == 0) n = 0;
        else if (big) n = (c > 8) ? 256 : 1 << (c - 1);
        else if (c < 11) n = 1 << (c - 1);
        else n = (c == 15) ? 1024 : 1024 - (1 << (19 - c));
        if (n == 0) return 32'h0010_0000;
        return bot ? {12'h000, 10'(n - 1), 10'h000} : {12'h000, 10'(tot - 1), 10'(tot - n)};
    endfunction
    task automatic sweep(input bit big, input bit bot);
        logic [31:0] e;
        for (int c = 0; c < 16; c++) begin
            status_write_cmd(8'(c << 2));
            axr(REG_RANGE);
            e = exp_rng(c, big, bot);
            chk(e[20] ? rd & 32'h0010_0000 : rd, e);
        end
        $display("test range sweep layout %0d bottom %0d done", big, bot);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        #400_000;
        err_count++;
        wrap_up();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        arst_n <= 1;
        axr(REG_STATUS);
        chk(rd, 32'h0000_0000);
        chk({30'h0, pin_ctrl_en, quad_lines_en}, 32'h2);
        cmd(OP_RPARAM_FREE, 26'h0, 8'h5A);
        cmd(OP_BANK_FREE, 26'h0, 8'hA5);
        cmd(OP_RPARAM_LOCKED, 26'h0, 8'h33);
        axr(REG_RPARAM);
        chk(rd, 32'h0000_005A);
        axr(REG_BANK);
        chk(rd, 32'h0000_00A5);
        $display("test volatile writes done");
        status_write_cmd(8'h04);
        cmd(OP_WRITE_ENABLE, 26'h0, 8'h0);
        cmd(OP_BLK_A, 26'h3FF_0000, 8'h0);
        chk(ref_s, 1);
        chk(op_code, OP_BLK_A);
        chk(op_addr, 32'h03FF_0000);
        axr(REG_STATUS);
        chk(rd, 32'h0000_0004);
        cmd(OP_WRITE_ENABLE, 26'h0, 8'h0);
        cmd(OP_PROG_A, 26'h3FE_FFFF, 8'h0);
        chk(go_s, 1);
        cmd(OP_WRITE_ENABLE, 26'h0, 8'h0);
        cmd(OP_CHIP_ERASE_A, 26'h0, 8'h0);
        chk({go_s, ref_s}, 2'b01);
        status_write_cmd(8'h00);
        cmd(OP_WRITE_ENABLE, 26'h0, 8'h0);
        cmd(OP_CHIP_ERASE_B, 26'h0, 8'h0);
        chk({go_s, ref_s}, 2'b10);
        $display("test erase and program gating done");
        status_write_cmd(8'h80);
        @(posedge clk_sys);
        wp_pin <= 0;
        status_write_cmd(8'h84);
        axr(REG_STATUS);
        chk(rd & 32'hFFFF_FFFD, 32'h0000_0080);
        @(posedge clk_sys);
        wp_pin <= 1;
        status_write_cmd(8'h84);
        axr(REG_STATUS);
        chk(rd, 32'h0000_0084);
        status_write_cmd(8'h00);
        @(posedge clk_sys);
        wp_pin <= 0;
        status_write_cmd(8'h08);
        axr(REG_STATUS);
        chk(rd, 32'h0000_0008);
        status_write_cmd(8'h40);
        chk({30'h0, pin_ctrl_en, quad_lines_en}, 32'h1);
        status_write_cmd(8'h00);
        chk({30'h0, pin_ctrl_en, quad_lines_en}, 32'h2);
        @(posedge clk_sys);
        wp_pin <= 1;
        $display("test status lock and pin function done");
        sweep(0, 0);
        axw(REG_CTRL, 32'h0000_0001);
        sweep(1, 0);
        cmd(OP_WRITE_ENABLE, 26'h0, 8'h0);
        cmd(OP_FUNC_WRITE, 26'h0, 8'h02);
        cmd(OP_WRITE_ENABLE, 26'h0, 8'h0);
        cmd(OP_FUNC_WRITE, 26'h0, 8'h00);
        axr(REG_FUNC);
        chk(rd, 32'h0000_0002);
        sweep(1, 1);
        axw(REG_CTRL, 32'h0000_0000);
        sweep(0, 1);
        axr(REG_REFUSED);
        chk(rd, 32'h0000_0002);
        axr(8'h1C);
        chk({30'h0, rr}, {30'h0, RESP_SLVERR});
        axw(8'h1C, 32'h0000_0001);
        chk({30'h0, rr}, {30'h0, RESP_SLVERR});
        $display("test unmapped access done");
        wrap_up();
    end
endmodule
